// File: design/ussel_defines.vh
// Register offsets, field positions and reset values for the shift clock select
`ifndef USSEL_DEFINES_VH
`define USSEL_DEFINES_VH
`define USSEL_ADDR_CTRL 8'hB8
`define USSEL_ADDR_PINPOS 8'hBC
`define USSEL_ADDR_DATA 8'hC0
`define USSEL_ADDR_STATUS 8'hC4
`define USSEL_CTRL_RESET 8'h00
`define USSEL_PINPOS_RESET 8'h00
`define USSEL_BIT_TOGGLE 0
`define USSEL_BIT_STROBE 1
`define USSEL_BIT_CS0 2
`define USSEL_BIT_CS1 3
`define USSEL_BIT_WM0 4
`define USSEL_BIT_WM1 5
`define USSEL_BIT_POS 0
`define USSEL_RESP_OKAY 2'b00
`define USSEL_RESP_SLVERR 2'b10
`endif

// File: design/ussel_serial_shift_clock_select.v
// Clock source selection, strobes and pin position for the shift interface
`timescale 1ns/10ps
// Contract
// - The clock source field clocks both the data register and the counter.
// - With the external clock the output moves on the edge opposite sampling.
// - With strobe or timer clocking the output latch is transparent.
// - Source zero without a strobe write gives no clock at all.
// - In strobe mode each strobe write shifts data once and counts once.
// - A strobe updates output at once and shifts in input from a cycle ago.
// - Source 01 clocks both by timer compare match, ignoring the strobe bit.
// - External mode shifts on rise (bit0=0) or fall (bit0=1), counts both.
// - With the upper source bit set the strobe bit selects the counter clock.
// - External mode with strobe bit set counts toggle writes only.
// - A toggle write inverts the clock port, shown when direction is out.
// - The strobe and toggle bits always read as zero.
// - The pin position bit routes data in, data out and clock to port A or B.
// - Bits 7 to 1 of the pin position register ignore writes and read zero.
// - The external clock input counts even with the wire mode disabled.
`include "ussel_defines.vh"
module ussel_serial_shift_clock_select #(
    parameter DATA_WIDTH = 8,
    parameter COUNT_WIDTH = 4
) (
    input wire clk_sys,
    input wire resetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire timerMatch,
    input wire clockPinDirection,
    input wire dataInPinB,
    input wire dataInPinA,
    input wire serialClockPinB,
    input wire serialClockPinA,
    output wire dataOutPinB,
    output wire dataOutPinA,
    output wire serialClockOutB,
    output wire serialClockOutA,
    output wire serialClockOeB,
    output wire serialClockOeA,
    output wire [1:0] wireModeSelect
);
// ***************************************************************
// Registers and input synchronisers
// ***************************************************************
reg [7:0] ctrl;
reg pinLocationSelect;
reg clockPort;
reg [DATA_WIDTH-1:0] shiftData;
reg [COUNT_WIDTH-1:0] bitCount;
reg dataOutLatch;
reg [1:0] diSyncB;
reg [1:0] diSyncA;
reg [1:0] ckSyncB;
reg [1:0] ckSyncA;
reg [1:0] tmSync;
reg ckPrev;
reg tmPrev;
reg diPrev;
wire [1:0] clockSourceSelect;
wire clockStrobeSel;
wire dataIn;
wire ckNow;
wire ckRise;
wire ckFall;
wire tmEvent;
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        diSyncB <= 2'h0;
        diSyncA <= 2'h0;
        ckSyncB <= 2'h0;
        ckSyncA <= 2'h0;
        tmSync <= 2'h0;
    end else begin
        diSyncB <= {diSyncB[0], dataInPinB};
        diSyncA <= {diSyncA[0], dataInPinA};
        ckSyncB <= {ckSyncB[0], serialClockPinB};
        ckSyncA <= {ckSyncA[0], serialClockPinA};
        tmSync <= {tmSync[0], timerMatch};
    end
end
// ***************************************************************
// Field decode
// ***************************************************************
assign clockSourceSelect = ctrl[`USSEL_BIT_CS1:`USSEL_BIT_CS0];
assign clockStrobeSel = ctrl[`USSEL_BIT_STROBE];
assign wireModeSelect = ctrl[`USSEL_BIT_WM1:`USSEL_BIT_WM0];
assign dataIn = pinLocationSelect ? diSyncA[1] : diSyncB[1];
assign ckNow = pinLocationSelect ? ckSyncA[1] : ckSyncB[1];
// ***************************************************************
// Edge detection
// ***************************************************************
assign ckRise = ckNow & ~ckPrev;
assign ckFall = ~ckNow & ckPrev;
assign tmEvent = tmSync[1] & ~tmPrev;
// ***************************************************************
// AXI4-Lite slave
// ***************************************************************
wire wrFire;
wire rdFire;
wire wrCtrl;
wire wrPin;
wire wrData;
wire [7:0] wrByte;
wire strobeWrite;
wire toggleWrite;
assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
assign s_axi_wready = s_axi_awready;
assign wrFire = s_axi_awready;
assign s_axi_arready = s_axi_arvalid & ~s_axi_rvalid;
assign rdFire = s_axi_arready;
assign wrByte = s_axi_wdata[7:0];
// ***************************************************************
// Register decode
// ***************************************************************
function hitCtrl;
    input [7:0] addr;
    begin
        hitCtrl = (addr[7:2] == `USSEL_ADDR_CTRL >> 2);
    end
endfunction
function hitPin;
    input [7:0] addr;
    begin
        hitPin = (addr[7:2] == `USSEL_ADDR_PINPOS >> 2);
    end
endfunction
function hitData;
    input [7:0] addr;
    begin
        hitData = (addr[7:2] == `USSEL_ADDR_DATA >> 2);
    end
endfunction
function hitStatus;
    input [7:0] addr;
    begin
        hitStatus = (addr[7:2] == `USSEL_ADDR_STATUS >> 2);
    end
endfunction
function known;
    input [7:0] addr;
    begin
        known = hitCtrl(addr) || hitPin(addr) ||
            hitData(addr) || hitStatus(addr);
    end
endfunction
assign wrCtrl = wrFire & s_axi_wstrb[0] & hitCtrl(s_axi_awaddr);
assign wrPin = wrFire & s_axi_wstrb[0] & hitPin(s_axi_awaddr);
assign wrData = wrFire & s_axi_wstrb[0] & hitData(s_axi_awaddr);
assign strobeWrite = wrCtrl & wrByte[`USSEL_BIT_STROBE] &
    (wrByte[`USSEL_BIT_CS1:`USSEL_BIT_CS0] == 2'b00);
assign toggleWrite = wrCtrl & wrByte[`USSEL_BIT_TOGGLE];
// ***************************************************************
// Read data
// ***************************************************************
reg [31:0] next_rdata;
always @* begin
    next_rdata = 32'h0000_0000;
    case (s_axi_araddr[7:2])
        `USSEL_ADDR_CTRL >> 2:
            next_rdata = {24'h000000, ctrl[7:2], 2'b00};
        `USSEL_ADDR_PINPOS >> 2:
            next_rdata = {31'h00000000, pinLocationSelect};
        `USSEL_ADDR_DATA >> 2:
            next_rdata = {{(32-DATA_WIDTH){1'b0}}, shiftData};
        `USSEL_ADDR_STATUS >> 2:
            next_rdata = {{(32-COUNT_WIDTH){1'b0}}, bitCount};
        default:
            next_rdata = 32'h0000_0000;
    endcase
end
// ***************************************************************
// Write response
// ***************************************************************
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `USSEL_RESP_OKAY;
    end else if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(s_axi_awaddr) ? `USSEL_RESP_OKAY :
            `USSEL_RESP_SLVERR;
    end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
    end
end
// ***************************************************************
// Read response
// ***************************************************************
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= `USSEL_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
    end else if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= known(s_axi_araddr) ? `USSEL_RESP_OKAY :
            `USSEL_RESP_SLVERR;
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end
// ***************************************************************
// Clock selection
// ***************************************************************
reg shiftClock;
reg countClock;
reg transparent;
always @* begin
    shiftClock = 1'b0;
    countClock = 1'b0;
    transparent = 1'b1;
    case (clockSourceSelect)
        2'b00: begin
            shiftClock = strobeWrite;
            countClock = strobeWrite;
        end
        2'b01: begin
            shiftClock = tmEvent;
            countClock = tmEvent;
        end
        2'b10: begin
            transparent = 1'b0;
            shiftClock = ckRise;
            countClock = clockStrobeSel ? toggleWrite :
                (ckRise | ckFall);
        end
        2'b11: begin
            transparent = 1'b0;
            shiftClock = ckFall;
            countClock = clockStrobeSel ? toggleWrite :
                (ckRise | ckFall);
        end
        default: begin
            shiftClock = 1'b0;
            countClock = 1'b0;
        end
    endcase
end
// ***************************************************************
// Edge history
// ***************************************************************
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        ckPrev <= 1'b0;
        tmPrev <= 1'b0;
        diPrev <= 1'b0;
    end else begin
        ckPrev <= ckNow;
        tmPrev <= tmSync[1];
        diPrev <= dataIn;
    end
end
// ***************************************************************
// Control and pin position registers
// ***************************************************************
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        ctrl <= `USSEL_CTRL_RESET;
    end else if (wrCtrl) begin
        ctrl[7:2] <= wrByte[7:2];
        ctrl[`USSEL_BIT_STROBE] <= wrByte[`USSEL_BIT_STROBE];
        ctrl[`USSEL_BIT_TOGGLE] <= 1'b0;
    end
end
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        pinLocationSelect <= 1'b0;
    end else if (wrPin) begin
        pinLocationSelect <= wrByte[`USSEL_BIT_POS];
    end
end
// ***************************************************************
// Clock port
// ***************************************************************
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        clockPort <= 1'b0;
    end else if (toggleWrite) begin
        clockPort <= ~clockPort;
    end
end
// ***************************************************************
// Shift register
// ***************************************************************
wire shiftIn;
assign shiftIn = (clockSourceSelect == 2'b00) ? diPrev : dataIn;
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        shiftData <= {DATA_WIDTH{1'b0}};
    end else if (shiftClock) begin
        shiftData <= {shiftData[DATA_WIDTH-2:0], shiftIn};
    end else if (wrData) begin
        shiftData <= wrByte;
    end
end
// ***************************************************************
// Counter
// ***************************************************************
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        bitCount <= {COUNT_WIDTH{1'b0}};
    end else if (countClock) begin
        bitCount <= bitCount + {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
    end
end
// ***************************************************************
// Output latch
// ***************************************************************
wire latchEdge;
assign latchEdge = clockSourceSelect[0] ? ckRise : ckFall;
always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
        dataOutLatch <= 1'b0;
    end else if (clockSourceSelect[1] && latchEdge) begin
        dataOutLatch <= shiftData[DATA_WIDTH-1];
    end
end
wire dataOut;
assign dataOut = transparent ? shiftData[DATA_WIDTH-1] : dataOutLatch;
// ***************************************************************
// Pin routing
// ***************************************************************
assign dataOutPinB = pinLocationSelect ? 1'b0 : dataOut;
assign dataOutPinA = pinLocationSelect ? dataOut : 1'b0;
assign serialClockOutB = pinLocationSelect ? 1'b0 : clockPort;
assign serialClockOutA = pinLocationSelect ? clockPort : 1'b0;
assign serialClockOeB = ~pinLocationSelect & clockPinDirection;
assign serialClockOeA = pinLocationSelect & clockPinDirection;
endmodule // ussel_serial_shift_clock_select

// File: verif/ussel_checker.sv
// Port checker for the shift clock select block
`timescale 1ns/10ps
module ussel_checker (
    input wire clk_sys,
    input wire resetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire clockPinDirection,
    input wire dataOutPinA,
    input wire dataOutPinB,
    input wire serialClockOutA,
    input wire serialClockOutB,
    input wire serialClockOeA,
    input wire serialClockOeB
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    chk_oe_dir: assert property ((serialClockOeA || serialClockOeB)
        |-> clockPinDirection) else $error("clock enable without output");
    chk_oe_one: assert property (!(serialClockOeA && serialClockOeB))
        else $error("both clock enables high");
    chk_dout_one: assert property (!(dataOutPinA && dataOutPinB))
        else $error("both data outputs high");
    chk_clk_one: assert property (!(serialClockOutA && serialClockOutB))
        else $error("both clock outputs high");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid
        && s_axi_awready && !s_axi_bvalid |=> s_axi_bvalid)
        else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        && !s_axi_rvalid |=> s_axi_rvalid) else $error("read data late");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
endmodule // ussel_checker
bind ussel_serial_shift_clock_select ussel_checker i_chk (.*);

// File: verif/ussel_ext_master.sv
// Behavioural external serial master driving clock and data pins
`timescale 1ns/10ps
module ussel_ext_master (
    input wire logic frameOn,
    output logic sclk,
    output logic sdata
);
    initial begin
        sclk = 1'h0;
        sdata = 1'h0;
        #7;
        forever begin
            #200;
            // Clock runs only inside a frame, idle data keeps moving
            if (frameOn) sclk = ~sclk;
            if (!sclk) sdata = ~sdata;
        end
    end
endmodule // ussel_ext_master

// File: verif/test_serial_shift_clock_select.sv
// Testbench for the shift clock select block
`timescale 1ns/10ps
module test_serial_shift_clock_select;
    logic clk_sys = 1'h0, resetn = 1'h0, frameOn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF, cnt = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, timerMatch = 1'h0;
    logic clockPinDirection = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, dataInPinA, dataInPinB, serialClockPinA;
    wire serialClockPinB, dataOutPinA, dataOutPinB, serialClockOutA;
    wire serialClockOutB, serialClockOeA, serialClockOeB;
    wire [1:0] s_axi_bresp, s_axi_rresp, wireModeSelect;
    wire [31:0] s_axi_rdata;
    int errors = 0, check_count = 0;
    assign serialClockPinA = serialClockPinB;
    assign dataInPinA = dataInPinB;
    ussel_serial_shift_clock_select i_dut (.*);
    ussel_ext_master i_master (.frameOn(frameOn), .sclk(serialClockPinB),
        .sdata(dataInPinB));
    initial forever #25 clk_sys = ~clk_sys;
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        @(posedge clk_sys);
        while (s_axi_awready !== 1'h1) @(posedge clk_sys);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        s_axi_bready <= 1'h1;
        @(posedge clk_sys);
        while (s_axi_bvalid !== 1'h1) @(posedge clk_sys);
        s_axi_bready <= 1'h0;
    endtask
    task automatic axr(input logic [7:0] a, input logic [7:0] e,
        input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        @(posedge clk_sys);
        while (s_axi_arready !== 1'h1) @(posedge clk_sys);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        @(posedge clk_sys);
        while (s_axi_rvalid !== 1'h1) @(posedge clk_sys);
        s_axi_rready <= 1'h0;
        chk({s_axi_rresp, s_axi_rdata}, {r, 24'h0, e});
    endtask
    task automatic t_strobe;
        axw(8'hC0, 8'h80);
        chk(dataOutPinB, 1'h1);
        repeat (3) axw(8'hB8, 8'h02);
        chk(dataOutPinB, 1'h0);
        cnt = cnt + 4'h3;
        axr(8'hC4, {4'h0, cnt}, 2'h0);
        axr(8'hB8, 8'h00, 2'h0);
        axw(8'hB8, 8'h00);
        axr(8'hC4, {4'h0, cnt}, 2'h0);
    endtask
    task automatic t_timer;
        axw(8'hB8, 8'h36);
        repeat (2) begin
            timerMatch <= 1'h1;
            repeat (4) @(posedge clk_sys);
            timerMatch <= 1'h0;
            repeat (4) @(posedge clk_sys);
        end
        cnt = cnt + 4'h2;
        axr(8'hC4, {4'h0, cnt}, 2'h0);
        axr(8'hB8, 8'h34, 2'h0);
        chk(wireModeSelect, 2'h3);
    endtask
    task automatic frame(input int cycles);
        frameOn <= 1'h1;
        repeat (cycles) @(posedge clk_sys);
        frameOn <= 1'h0;
        repeat (6) @(posedge clk_sys);
    endtask
    task automatic t_extern;
        axw(8'hB8, 8'h08);
        frame(32);
        cnt = cnt + 4'h8;
        axr(8'hC4, {4'h0, cnt}, 2'h0);
        axw(8'hB8, 8'h0A);
        frame(16);
        axr(8'hC4, {4'h0, cnt}, 2'h0);
        repeat (2) axw(8'hB8, 8'h0B);
        cnt = cnt + 4'h2;
        axr(8'hC4, {4'h0, cnt}, 2'h0);
    endtask
    task automatic t_pins;
        axr(8'hBC, 8'h00, 2'h0);
        clockPinDirection <= 1'h1;
        axw(8'hB8, 8'h01);
        chk({serialClockOutB, serialClockOeB}, 2'h3);
        axw(8'hBC, 8'hFF);
        axr(8'hBC, 8'h01, 2'h0);
        chk({serialClockOutA, serialClockOutB}, 2'h2);
        chk({serialClockOeA, serialClockOeB, dataOutPinB}, 3'h4);
        axr(8'hF0, 8'h00, 2'h2);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        resetn <= 1'h1;
        @(posedge clk_sys);
        t_strobe();
        t_timer();
        t_extern();
        t_pins();
        test_done();
    end
    initial begin
        #3000000;
        errors++;
        test_done();
    end
endmodule // test_serial_shift_clock_select
